// ==== tc_result_params.svh ====
// Offsets, field positions, reset values and timing figures of the thermocouple result registers.
// Function
// - Compensated result is delta plus cold junction.
// - Compensated result: 16-bit signed, 0.0625 C LSB.
// - Type-selected coefficients turn microvolts into degrees.
// - Delta result: 16-bit signed, same weights.
// - Cold-junction register is double-buffered, read coherent.
// - Cold-junction bits 15..12 replicate the sign.
// - Cold-junction resolution: fine 250 ms, coarse 63 ms.
// - Coarse cold-junction resolution clears bits 1 and 0.
// - 18-bit converter result goes to raw register.
// - Converter resolutions 18/16/14/12 bits with timings.
// - Raw code 24-bit signed, bits 23..18 sign.
// - Out of range: skip commit, keep temperature results; raw still updates.
// - Three-bit type field selects K,J,T,N,S,E,B,R.
// - Done flag set per in-range conversion, software clears.
`ifndef TC_RESULT_PARAMS_SVH
`define TC_RESULT_PARAMS_SVH

// Register pointer values.
`define OFS_COMPENSATED 8'h00
`define OFS_DELTA 8'h01
`define OFS_COLD 8'h02
`define OFS_RAW 8'h03

// Reset values.
`define RST_TEMP 16'h0000
`define RST_RAW 24'h000000

// Field positions.
`define TEMP_SIGN_BIT 15
`define COLD_SIGN_LO 12
`define RAW_SIGN_LO 18
`define CONFIG_COLD_RES_BIT 7

// Converter resolution codes.
`define ADC_RES_18 2'h0
`define ADC_RES_16 2'h1
`define ADC_RES_14 2'h2
`define ADC_RES_12 2'h3

// Thermocouple type codes.
`define TYPE_K 3'h0
`define TYPE_J 3'h1
`define TYPE_T 3'h2
`define TYPE_N 3'h3
`define TYPE_S 3'h4
`define TYPE_E 3'h5
`define TYPE_B 3'h6
`define TYPE_R 3'h7

// Clock rate and conversion times.
`define CLK_KHZ 10000
`define ADC_T18_MS 320
`define ADC_T16_MS 80
`define ADC_T14_MS 20
`define ADC_T12_MS 5
`define CJ_FINE_MS 250
`define CJ_COARSE_MS 63

// Scaling of the coefficient product back to 0.0625 C units.
`define GAIN_SHIFT 16

`endif

// ==== tc_result_pkg.sv ====
// Types shared by the thermocouple result logic.
package tc_result_pkg;
	typedef enum logic [0:0] {ph_wait, ph_commit} phase_e;
	typedef logic signed [15:0] temp_t;
	typedef logic signed [23:0] raw_t;
endpackage

// ==== tc_result_regs.sv ====
// Thermocouple result registers: sampling, conversion, compensation and register read port.
`timescale 1ns/100ps
`include "tc_result_params.svh"
module tc_result_regs #(
	parameter int ADC_T18_CYC = `ADC_T18_MS * `CLK_KHZ, // 18-bit conversion period in cycles.
	parameter int ADC_T16_CYC = `ADC_T16_MS * `CLK_KHZ, // 16-bit conversion period in cycles.
	parameter int ADC_T14_CYC = `ADC_T14_MS * `CLK_KHZ, // 14-bit conversion period in cycles.
	parameter int ADC_T12_CYC = `ADC_T12_MS * `CLK_KHZ, // 12-bit conversion period in cycles.
	parameter int CJ_FINE_CYC = `CJ_FINE_MS * `CLK_KHZ, // Fine cold-junction period in cycles.
	parameter int CJ_COARSE_CYC = `CJ_COARSE_MS * `CLK_KHZ // Coarse cold-junction period in cycles.
) (
	input wire logic clk, // System clock, 10 MHz.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic [17:0] adc_code, // Converter output code from the front end.
	input wire logic [12:0] cj_code, // Ambient sensor code, 0.0625 C LSB, signed.
	input wire logic [2:0] tc_type, // Thermocouple type select.
	input wire logic [1:0] adc_res, // Converter resolution select.
	input wire logic cj_coarse, // Cold-junction coarse resolution, config bit 7.
	input wire logic [7:0] rd_addr, // Register pointer.
	input wire logic rd_en, // Read strobe, one cycle.
	input wire logic read_hold, // High while a multi-byte read is in progress.
	input wire logic done_clear, // Clears the done flag, one cycle.
	output logic [23:0] rd_data, // Read data, low bits hold 16-bit results.
	output logic conversion_done_flag, // Set when an in-range conversion completes.
	output logic input_range // Converter input or result out of range.
);
	logic [17:0] adc_s1_reg, adc_s2_reg;
	logic [12:0] cj_s1_reg, cj_s2_reg;
	logic [31:0] adc_cnt_reg, adc_cnt_next;
	logic [31:0] cj_cnt_reg, cj_cnt_next;
	tc_result_pkg::phase_e phase_reg, phase_next;
	tc_result_pkg::raw_t raw_reg, raw_next;
	tc_result_pkg::temp_t delta_reg, delta_next;
	tc_result_pkg::temp_t hot_reg, hot_next;
	tc_result_pkg::temp_t cj_reg, cj_next;
	tc_result_pkg::temp_t cj_shadow_reg, cj_shadow_next;
	tc_result_pkg::temp_t conv_delta_reg, conv_delta_next;
	logic conv_bad_reg, conv_bad_next;
	logic done_reg, done_next;
	logic range_reg, range_next;
	logic [23:0] rd_data_reg, rd_data_next;
	logic adc_tick, cj_tick;

	// First-order slope per type, 0.0625 C per microvolt scaled by 2^16; values are representative.
	function automatic logic signed [16:0] type_gain(input logic [2:0] t);
		case (t)
			`TYPE_K: type_gain = 17'sh063E7;
			`TYPE_J: type_gain = 17'sh04E84;
			`TYPE_T: type_gain = 17'sh0619E;
			`TYPE_N: type_gain = 17'sh0A2C3;
			`TYPE_S: type_gain = 17'h1FFFF >> 1;
			`TYPE_E: type_gain = 17'sh04235;
			`TYPE_B: type_gain = 17'h1FFFF >> 1;
			default: type_gain = 17'h1FFFF >> 1;
		endcase
	endfunction

	// Largest EMF magnitude in microvolts that each type may present.
	function automatic logic [23:0] type_limit(input logic [2:0] t);
		case (t)
			`TYPE_K: type_limit = 24'h00D666;
			`TYPE_J: type_limit = 24'h010F58;
			`TYPE_T: type_limit = 24'h005406;
			`TYPE_N: type_limit = 24'h00BEFC;
			`TYPE_S: type_limit = 24'h0048CA;
			`TYPE_E: type_limit = 24'h012AE1;
			`TYPE_B: type_limit = 24'h0034EE;
			default: type_limit = 24'h0053A2;
		endcase
	endfunction

	// Period of the selected converter resolution.
	function automatic logic [31:0] adc_period(input logic [1:0] r);
		case (r)
			`ADC_RES_18: adc_period = 32'(ADC_T18_CYC);
			`ADC_RES_16: adc_period = 32'(ADC_T16_CYC);
			`ADC_RES_14: adc_period = 32'(ADC_T14_CYC);
			default: adc_period = 32'(ADC_T12_CYC);
		endcase
	endfunction

	// Mask of valid raw bits; unused low bits are dropped while the sign bits stay.
	function automatic logic [23:0] raw_mask(input logic [1:0] r);
		case (r)
			`ADC_RES_18: raw_mask = 24'hFFFFFF;
			`ADC_RES_16: raw_mask = 24'hFFFFFC;
			`ADC_RES_14: raw_mask = 24'hFFFFF0;
			default: raw_mask = 24'hFFFFC0;
		endcase
	endfunction

	// Front-end codes come from the analog domain, so each passes two flip-flops first.
	always_ff @(posedge clk) begin
		adc_s1_reg <= adc_code;
		adc_s2_reg <= adc_s1_reg;
		cj_s1_reg <= cj_code;
		cj_s2_reg <= cj_s1_reg;
	end

	assign adc_tick = (adc_cnt_reg == 32'h0);
	assign cj_tick = (cj_cnt_reg == 32'h0);

	// Sequencing, conversion and the result registers.
	always_comb begin
		logic signed [40:0] prod;
		logic [23:0] raw_val;
		logic [23:0] mag;
		logic done_set;
		prod = '0;
		done_set = 1'b0;
		raw_val = '0;
		mag = '0;
		adc_cnt_next = adc_tick ? adc_period(adc_res) - 32'h1 : adc_cnt_reg - 32'h1;
		cj_cnt_next = cj_tick ? (cj_coarse ? 32'(CJ_COARSE_CYC) : 32'(CJ_FINE_CYC)) - 32'h1 : cj_cnt_reg - 32'h1;
		phase_next = phase_reg;
		raw_next = raw_reg;
		delta_next = delta_reg;
		hot_next = hot_reg;
		cj_next = cj_reg;
		cj_shadow_next = cj_shadow_reg;
		conv_delta_next = conv_delta_reg;
		conv_bad_next = conv_bad_reg;
		done_next = done_reg;
		range_next = range_reg;
		// The ambient sample lands in the shadow; coarse mode keeps the two low bits clear.
		if (cj_tick) begin
			cj_shadow_next = {{3{cj_s2_reg[12]}}, cj_s2_reg};
			if (cj_coarse) begin
				cj_shadow_next[1:0] = 2'h0;
			end
		end
		// A converter sample is sign-extended, trimmed, then scaled by the type coefficient.
		if (adc_tick) begin
			raw_val = {{6{adc_s2_reg[17]}}, adc_s2_reg} & raw_mask(adc_res);
			raw_next = raw_val;
			mag = raw_val[23] ? 24'(-raw_val) : raw_val;
			prod = $signed(raw_val) * type_gain(tc_type);
			conv_delta_next = 16'(prod >>> `GAIN_SHIFT);
			conv_bad_next = (mag > type_limit(tc_type));
			phase_next = tc_result_pkg::ph_commit;
		end
		// Commit waits for any read in progress, so all three temperatures change together.
		case (phase_reg)
			tc_result_pkg::ph_wait: begin
			end
			tc_result_pkg::ph_commit: begin
				if (!read_hold && !adc_tick) begin
					phase_next = tc_result_pkg::ph_wait;
					range_next = conv_bad_reg;
					if (!conv_bad_reg) begin
						delta_next = conv_delta_reg;
						cj_next = cj_shadow_reg;
						hot_next = 16'(conv_delta_reg + cj_shadow_reg);
						done_next = 1'b1;
						done_set = 1'b1;
					end
				end
			end
			default: phase_next = tc_result_pkg::ph_wait;
		endcase
		// A completion in the same cycle as a clear wins, even when the flag was already up.
		// Otherwise a poller could clear a fresh completion and wait a whole extra period.
		if (done_clear && !done_set) begin
			done_next = 1'b0;
		end
	end

	// Reads only copy a value out into rd_data; no result register changes because of them.
	always_comb begin
		rd_data_next = rd_data_reg;
		if (rd_en) begin
			if (rd_addr == `OFS_COMPENSATED) begin
				rd_data_next = {8'h00, hot_reg};
			end else if (rd_addr == `OFS_DELTA) begin
				rd_data_next = {8'h00, delta_reg};
			end else if (rd_addr == `OFS_COLD) begin
				rd_data_next = {8'h00, cj_reg};
			end else if (rd_addr == `OFS_RAW) begin
				rd_data_next = raw_reg;
			end else begin
				rd_data_next = 24'h000000;
			end
		end
	end

	// State registers; all results start at zero.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			adc_cnt_reg <= 32'h0000000F;
			cj_cnt_reg <= 32'h00000007;
			phase_reg <= tc_result_pkg::ph_wait;
			raw_reg <= `RST_RAW;
			delta_reg <= `RST_TEMP;
			hot_reg <= `RST_TEMP;
			cj_reg <= `RST_TEMP;
			cj_shadow_reg <= `RST_TEMP;
			conv_delta_reg <= `RST_TEMP;
			conv_bad_reg <= 1'b0;
			done_reg <= 1'b0;
			range_reg <= 1'b0;
			rd_data_reg <= `RST_RAW;
		end else begin
			adc_cnt_reg <= adc_cnt_next;
			cj_cnt_reg <= cj_cnt_next;
			phase_reg <= phase_next;
			raw_reg <= raw_next;
			delta_reg <= delta_next;
			hot_reg <= hot_next;
			cj_reg <= cj_next;
			cj_shadow_reg <= cj_shadow_next;
			conv_delta_reg <= conv_delta_next;
			conv_bad_reg <= conv_bad_next;
			done_reg <= done_next;
			range_reg <= range_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign conversion_done_flag = done_reg;
	assign input_range = range_reg;

	// Checks on the result logic.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic commit_ok;
	assign commit_ok = (phase_reg == tc_result_pkg::ph_commit) && !read_hold && !adc_tick && !conv_bad_reg;

	sum_invariant_a: assert property (hot_reg == 16'(delta_reg + cj_reg))
		else $error("compensated result is not delta plus cold junction");
	cold_sign_a: assert property (cj_reg[15:12] == {4{cj_reg[15]}})
		else $error("cold-junction sign bits disagree");
	cold_coarse_a: assert property (cj_tick && cj_coarse |=> cj_shadow_reg[1:0] == 2'h0)
		else $error("coarse cold-junction low bits not clear");
	raw_sign_a: assert property (raw_reg[23:18] == {6{raw_reg[17]}})
		else $error("raw sign extension broken");
	raw_trim_a: assert property (adc_tick && adc_res == `ADC_RES_12 |=> raw_reg[5:0] == 6'h00)
		else $error("12-bit raw low bits not clear");
	range_hold_a: assert property ((phase_reg == tc_result_pkg::ph_commit) && conv_bad_reg && !read_hold && !adc_tick
		|=> $stable(delta_reg) && $stable(hot_reg) && $stable(cj_reg) && input_range)
		else $error("results changed on out-of-range conversion");
	done_set_a: assert property (commit_ok
		|=> conversion_done_flag && hot_reg == 16'($past(conv_delta_reg) + $past(cj_shadow_reg)))
		else $error("done flag or result missing after conversion");
	hold_block_a: assert property (read_hold |=> $stable(cj_reg))
		else $error("cold-junction changed during a held read");
	read_comp_a: assert property (rd_en && rd_addr == `OFS_COMPENSATED |=> rd_data == {8'h00, $past(hot_reg)})
		else $error("compensated read returned wrong data");
	read_harmless_a: assert property (rd_en && phase_reg == tc_result_pkg::ph_wait && !adc_tick
		|=> $stable(hot_reg) && $stable(raw_reg))
		else $error("read disturbed a result register");
	// Each mapped pointer returns its own register one cycle after the strobe; unmapped pointers return zero.
	read_delta_a: assert property (rd_en && rd_addr == `OFS_DELTA |=> rd_data == {8'h00, $past(delta_reg)})
		else $error("delta read returned wrong data");
	read_cold_a: assert property (rd_en && rd_addr == `OFS_COLD |=> rd_data == {8'h00, $past(cj_reg)})
		else $error("cold-junction read returned wrong data");
	read_raw_a: assert property (rd_en && rd_addr == `OFS_RAW |=> rd_data == $past(raw_reg))
		else $error("raw read returned wrong data");
	read_other_a: assert property (rd_en && rd_addr > `OFS_RAW |=> rd_data == 24'h000000)
		else $error("unmapped pointer did not read zero");
	// A clear with no completion beside it must take the flag down.
	done_clear_a: assert property (done_clear && !commit_ok |=> !conversion_done_flag)
		else $error("done flag survived a clear");
	cold_commit_a: assert property (commit_ok |=> cj_reg == $past(cj_shadow_reg))
		else $error("cold-junction result not taken from the shadow");
	// Reload values; a wrong period would only show as a slow or fast update rate.
	conv_period_a: assert property (adc_tick && adc_res == `ADC_RES_12
		|=> adc_cnt_reg == 32'(ADC_T12_CYC) - 32'h1)
		else $error("12-bit conversion period wrong");
	cold_period_a: assert property (cj_tick && cj_coarse |=> cj_cnt_reg == 32'(CJ_COARSE_CYC) - 32'h1)
		else $error("coarse cold-junction period wrong");

	commit_c: cover property (commit_ok ##1 conversion_done_flag);
	range_c: cover property (conv_bad_reg && phase_reg == tc_result_pkg::ph_commit ##1 input_range);
	coarse_c: cover property (cj_tick && cj_coarse);
	clear_c: cover property (conversion_done_flag ##1 done_clear ##1 !conversion_done_flag);
	hold_c: cover property (read_hold && phase_reg == tc_result_pkg::ph_commit);
endmodule

// ==== tc_reader.sv ====
// Reader model: polls the result registers the way the two-wire bus master does.
`timescale 1ns/100ps
module tc_reader (
	input wire logic clk, // System clock.
	output logic rd_en, // Read strobe.
	output logic [7:0] rd_addr, // Register pointer.
	output logic read_hold, // High across a multi-byte read.
	output logic done_clear // Clears the done flag.
);
	// Idle values at time zero.
	initial begin
		rd_en = 1'b0;
		rd_addr = 8'hA5;
		read_hold = 1'b0;
		done_clear = 1'b0;
	end
	// One read per falling edge, so calls in a row give back-to-back reads.
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		rd_en = 1'b1;
		rd_addr = a;
	endtask
	// The pointer is scrambled between reads so a stale pointer never matches a register.
	task automatic idle();
		@(negedge clk);
		rd_en = 1'b0;
		rd_addr = ~rd_addr;
	endtask
	// A one-cycle clear pulse.
	task automatic clr();
		@(negedge clk);
		done_clear = 1'b1;
		@(negedge clk);
		done_clear = 1'b0;
	endtask
	// Holding the bus freezes the three temperature results; the raw register still updates.
	task automatic hold(input logic v);
		@(negedge clk);
		read_hold = v;
	endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the thermocouple result registers.
`timescale 1ns/100ps
module tb;
	typedef struct {string n; logic [23:0] m; logic [23:0] e;} note_s;
	logic clk = 1'b0, pend = 1'b0;
	logic nrst, cj_coarse;
	logic [17:0] adc_code;
	logic [12:0] cj_code;
	logic [2:0] tc_type;
	logic [1:0] adc_res;
	logic [23:0] rd_data, ce;
	logic [7:0] rd_addr;
	logic rd_en, read_hold, done_clear, conversion_done_flag, input_range;
	int errors = 0, checked = 0;
	note_s q[$];
	note_s n;
	tc_result_regs #(.ADC_T18_CYC(80), .ADC_T16_CYC(70), .ADC_T14_CYC(60), .ADC_T12_CYC(50), .CJ_FINE_CYC(40),
		.CJ_COARSE_CYC(30)) dut (.clk(clk), .nrst(nrst), .adc_code(adc_code), .cj_code(cj_code), .tc_type(tc_type),
		.adc_res(adc_res), .cj_coarse(cj_coarse), .rd_addr(rd_addr), .rd_en(rd_en), .read_hold(read_hold),
		.done_clear(done_clear), .rd_data(rd_data), .conversion_done_flag(conversion_done_flag),
		.input_range(input_range));
	tc_reader rdr (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .read_hold(read_hold), .done_clear(done_clear));
	// A 100 ns clock.
	always #50 clk = ~clk;
	function automatic logic [23:0] cold_of(input logic [12:0] c, input logic k);
		return {8'h00, {3{c[12]}}, c[12:2], c[1:0] & {2{~k}}};
	endfunction
	function automatic logic [23:0] raw_of(input logic [17:0] a, input logic [1:0] r);
		return {{6{a[17]}}, a} & (r == 2'h0 ? 24'hFFFFFF : r == 2'h1 ? 24'hFFFFFC : r == 2'h2 ? 24'hFFFFF0 : 24'hFFFFC0);
	endfunction
	// Reader's scaling: high octet times 16 plus low octet over 16, less 4096 if negative, kept in sixteenths.
	function automatic int sixteenths(input logic [7:0] result_high_octet, input logic [7:0] result_low_octet);
		int v;
		v = 256 * int'(result_high_octet) + int'(result_low_octet);
		if (result_high_octet[7]) v = v - 65536;
		return v;
	endfunction
	task automatic finish_test();
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [23:0] e, input logic [23:0] v);
		checked++;
		if (v !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic note(input string s, input logic [23:0] m, input logic [23:0] e);
		q.push_back(note_s'{s, m, e});
	endtask
	task automatic setin(input logic [17:0] a, input logic [12:0] c, input logic k, input logic [1:0] r,
		input logic [2:0] t);
		@(negedge clk);
		adc_code = a;
		cj_code = c;
		cj_coarse = k;
		adc_res = r;
		tc_type = t;
	endtask
	// Bounded wait for the done flag or the range flag; running out ends the run.
	task automatic waitfor(input logic g);
		int k;
		for (k = 0; k < 400; k++) begin
			@(negedge clk);
			if ((g ? input_range : conversion_done_flag) === 1'b1) break;
		end
		if (k == 400) begin
			errors++;
			finish_test();
		end
	endtask
	// The c conversions, three in most calls and two in the type loop, make sure the new inputs crossed the sync flops and the shadow.
	task automatic conv(input int c);
		repeat (c) begin
			rdr.clr();
			waitfor(1'b0);
		end
	endtask
	// The done flag must stay low while commits are held back.
	task automatic watch();
		repeat (300) begin
			@(negedge clk);
			chk("done", 24'h0, {23'h0, conversion_done_flag});
		end
	endtask
	task automatic read4(input logic [23:0] cm, input logic [23:0] cv, input logic [23:0] dm, input logic [23:0] dv,
		input logic [23:0] kv);
		note("compensated", cm, cv);
		note("delta", dm, dv);
		note("cold", 24'hFFFFFF, kv);
		note("raw", 24'hFFFFFF, raw_of(adc_code, adc_res));
		for (int a = 0; a < 4; a++) rdr.rd(8'(a));
		rdr.idle();
	endtask
	// Each answer stands one cycle after its strobe and is compared with the oldest note then.
	always @(posedge clk) pend <= rd_en;
	always @(negedge clk) begin
		if (pend) begin
			if (q.size() == 0) chk("spare", 24'h0, 24'hFFFFFF);
			else begin
				n = q.pop_front();
				chk(n.n, n.e, rd_data & n.m);
				if (n.n == "cold") begin
					chk("cold_deg", 24'($signed(n.e[15:0])), 24'(sixteenths(rd_data[15:8], rd_data[7:0])));
				end
			end
		end
	end
	// Main sequence.
	initial begin
		logic [31:0] r;
		nrst = 1'b0;
		cj_coarse = 1'b0;
		adc_code = 18'h00000;
		cj_code = 13'h0000;
		tc_type = 3'h0;
		adc_res = 2'h0;
		void'($urandom(32'h04B6));
		repeat (16) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		for (int a = 0; a < 5; a++) note("reset", 24'hFFFFFF, 24'h000000);
		for (int a = 0; a < 5; a++) rdr.rd(8'(a));
		rdr.idle();
		chk("done", 24'h0, {23'h0, conversion_done_flag});
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			setin(i[0] ? 18'h00000 : {{7{r[31]}}, r[10:1], 1'b1}, r[28:16], i[0], i[2:1], 3'(r[13:11]));
			conv(3);
			ce = cold_of(r[28:16], i[0]);
			if (i[0]) read4(24'hFFFFFF, ce, 24'hFFFFFF, 24'h0, ce);
			else read4(24'hFF0000, 24'h0, 24'hFF8000, {8'h00, r[31], 15'h0}, ce);
		end
		for (int t = 0; t < 8; t++) begin
			r = $urandom;
			setin(18'h0012C, r[12:0], 1'b0, 2'h3, 3'(t));
			conv(2);
			chk("range", 24'h0, {23'h0, input_range});
			chk("done", 24'h1, {23'h0, conversion_done_flag});
			read4(24'hFF0000, 24'h0, 24'hFF8000, 24'h0, cold_of(r[12:0], 1'b0));
		end
		setin(18'h00000, 13'h1F00, 1'b0, 2'h0, 3'h0);
		conv(3);
		ce = cold_of(13'h1F00, 1'b0);
		setin(18'h1FFFF, 13'h1F00, 1'b0, 2'h0, 3'h0);
		waitfor(1'b1);
		setin(18'h1FFFF, 13'h0123, 1'b0, 2'h0, 3'h0);
		rdr.clr();
		watch();
		read4(24'hFFFFFF, ce, 24'hFFFFFF, 24'h0, ce);
		setin(18'h00000, 13'h0040, 1'b1, 2'h1, 3'h0);
		conv(3);
		chk("range", 24'h0, {23'h0, input_range});
		ce = cold_of(13'h0040, 1'b1);
		rdr.hold(1'b1);
		setin(18'h00000, 13'h1ABC, 1'b0, 2'h1, 3'h0);
		rdr.clr();
		watch();
		read4(24'hFFFFFF, ce, 24'hFFFFFF, 24'h0, ce);
		rdr.hold(1'b0);
		conv(3);
		ce = cold_of(13'h1ABC, 1'b0);
		read4(24'hFFFFFF, ce, 24'hFFFFFF, 24'h0, ce);
		repeat (4) @(posedge clk);
		chk("queue", 24'h0, 24'(q.size()));
		finish_test();
	end
endmodule
